/* File: shared/atx_pkg.sv */
// Shared constants and types for the AV transmit credit shaper arbiter
package atx_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] ATX_GAIN_OFS   = 8'h00;
  localparam logic [7:0] ATX_DRAIN_OFS  = 8'h04;
  localparam logic [7:0] ATX_CREDIT_OFS = 8'h08;
  localparam logic [7:0] ATX_STATE_OFS  = 8'h0C;

  // Slope fields sit in the low bits of their register
  localparam int ATX_RATE_W = 16;
  localparam int ATX_RATE_LSB = 0;

  // Reset slopes give up to 75 % of the line to AV traffic
  localparam logic [ATX_RATE_W-1:0] ATX_GAIN_RST  = 16'h1800;
  localparam logic [ATX_RATE_W-1:0] ATX_DRAIN_RST = 16'h0800;

  // Credit accumulator width and its fixed saturation bounds
  localparam int ATX_CR_W = 26;
  localparam logic signed [ATX_CR_W-1:0] ATX_CREDIT_UPPER = 26'sh0BD_C000;
  localparam logic signed [ATX_CR_W-1:0] ATX_CREDIT_LOWER = 26'sh342_4000;

  // Longest legacy frame in bytes before it is marked bad
  localparam logic [11:0] ATX_LEG_MAX_LEN = 12'h5EE;

  // Status register field positions
  localparam int ATX_STATE_LSB = 0;
  localparam int ATX_OVERSIZE_BIT = 4;

  // Which source owns the outbound stream
  typedef enum logic [3:0] {
    ATX_SEL_IDLE = 4'b0001,
    ATX_SEL_AV   = 4'b0010,
    ATX_SEL_TPP  = 4'b0100,
    ATX_SEL_LEG  = 4'b1000
  } atx_sel_t;

endpackage : atx_pkg

/* File: design/atx_credit.sv */
// Signed credit accumulator of the traffic shaper with fixed saturation
`timescale 1ns/100ps
module atx_credit
  import atx_pkg::*;
(
  input  wire logic                        clk_sys,    // Transmit clock
  input  wire logic                        rst_n,      // Async reset, active low
  input  wire logic [atx_pkg::ATX_RATE_W-1:0] gain_rate, // Per-byte credit gain
  input  wire logic [atx_pkg::ATX_RATE_W-1:0] drain_rate, // Per-byte credit drain
  input  wire logic                        tick_gain,  // Byte time with AV waiting
  input  wire logic                        tick_drain, // AV byte sent
  input  wire logic                        clear_pos,  // No AV queued
  output logic signed [atx_pkg::ATX_CR_W-1:0] credit_q // Current credit
);
  import atx_pkg::*;

  logic signed [ATX_CR_W:0]   sum;
  logic signed [ATX_CR_W-1:0] credit_d;

  // One extra bit of headroom so a step never wraps before saturation
  always_comb begin
    sum = {credit_q[ATX_CR_W-1], credit_q};
    if (tick_gain) begin
      sum = sum + $signed({11'h000, gain_rate});
    end
    if (tick_drain) begin
      sum = sum - $signed({11'h000, drain_rate});
    end
    if (sum > $signed({ATX_CREDIT_UPPER[ATX_CR_W-1], ATX_CREDIT_UPPER})) begin
      credit_d = ATX_CREDIT_UPPER;
    end else if (sum < $signed({ATX_CREDIT_LOWER[ATX_CR_W-1], ATX_CREDIT_LOWER})) begin
      credit_d = ATX_CREDIT_LOWER;
    end else begin
      credit_d = sum[ATX_CR_W-1:0];
    end
    // Positive balance is dropped, a debt is kept
    if (clear_pos && credit_d > 0) begin
      credit_d = '0;
    end
  end

  // Accumulator, one update per byte time at most
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      credit_q <= '0;
    end else begin
      credit_q <= credit_d;
    end
  end

  credit_bounds_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    credit_q <= ATX_CREDIT_UPPER && credit_q >= ATX_CREDIT_LOWER)
    else $error("credit left its bounds");

  credit_drain_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tick_drain && !tick_gain && !clear_pos && credit_q < 0 &&
     credit_q > ATX_CREDIT_LOWER + 26'sh001_0000)
    |=> credit_q == $past(credit_q) - $signed({11'h000, $past(drain_rate)}))
    else $error("credit did not drain by the drain rate");

  credit_gain_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (tick_gain && !tick_drain && credit_q < ATX_CREDIT_UPPER - 26'sh001_0000)
    |=> credit_q == $past(credit_q) + $signed({11'h000, $past(gain_rate)}))
    else $error("credit did not gain by the gain rate");

  pos_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clear_pos && !tick_drain && credit_q > 0) |=> credit_q == 0)
    else $error("positive credit kept with no AV queued");

  neg_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clear_pos && !tick_drain && !tick_gain && credit_q < 0) |=> $stable(credit_q))
    else $error("negative credit changed while AV idle");

endmodule : atx_credit

/* File: design/atx_arbiter.sv */
// AV transmit arbiter with credit shaper, fed by AV, timing and legacy sources
//
// Behaviour
// - At frame boundary pick AV if in budget, else timing packet, else legacy.
// - AV frame may start only while credit is zero or above.
// - Negative credit blocks AV; a waiting legacy frame goes instead.
// - With no AV frame queued, positive credit is forced to zero.
// - AV valid dropping between frames keeps a debt, clears a surplus.
// - Credit rises at the gain rate while AV waits.
// - Credit falls at the drain rate while AV bytes are sent.
// - Credit saturates at fixed, hardwired upper and lower bounds.
// - Gain value is AV share times 8192, added per non-AV byte.
// - Drain value is remaining share times 8192, taken per AV byte.
// - Reset slopes reserve up to 75 percent for AV.
// - Slopes work per byte, so line rate never needs reprogramming.
// - Valid high and in budget after a frame keeps AV selected.
// - Over budget at frame end switches away from AV regardless of valid.
// - Legacy input is full duplex, no jumbo, VLAN allowed, no pause.
// - AV input has legacy beat timing; only between-frame valid differs.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module atx_arbiter
  import atx_pkg::*;
(
  input  wire logic        clk_sys,       // Transmit clock, 125 MHz
  input  wire logic        rst_n,         // Async reset, active low
  // APB slave
  input  wire logic        psel,          // Slave select
  input  wire logic        penable,       // Access phase
  input  wire logic        pwrite,        // Write when high
  input  wire logic [7:0]  paddr,         // Byte address
  input  wire logic [31:0] pwdata,        // Write data
  output logic      [31:0] prdata,        // Read data
  output logic             pready,        // Transfer done
  output logic             pslverr,       // Unmapped address
  // AV stream source
  input  wire logic [7:0]  av_tdata,      // AV byte
  input  wire logic        av_source_valid, // AV byte valid / frame queued
  input  wire logic        av_tlast,      // AV last byte
  output logic             av_tready,     // AV byte taken
  // Timing packet buffer
  input  wire logic [7:0]  tpp_tdata,     // Timing packet byte
  input  wire logic        tpp_tvalid,    // Timing packet pending
  input  wire logic        tpp_tlast,     // Timing packet last byte
  output logic             tpp_tready,    // Timing byte taken
  // Legacy stream source
  input  wire logic [7:0]  leg_tdata,     // Legacy byte
  input  wire logic        leg_tvalid,    // Legacy byte valid
  input  wire logic        leg_tlast,     // Legacy last byte
  output logic             leg_tready,    // Legacy byte taken
  // Toward the MAC transmitter
  output logic [7:0]       mac_tdata,     // Outbound byte
  output logic             mac_tvalid,    // Outbound byte valid
  output logic             mac_tlast,     // Outbound last byte
  output logic             mac_tuser,     // Bad frame mark on last byte
  input  wire logic        mac_tready     // MAC takes a byte this cycle
);
  import atx_pkg::*;

  atx_sel_t sel_q;
  atx_sel_t sel_d;

  logic [ATX_RATE_W-1:0]      gain_q;
  logic [ATX_RATE_W-1:0]      drain_q;
  logic signed [ATX_CR_W-1:0] credit;
  logic                       out_av_q;
  logic                       oversize_q;
  logic [11:0]                leg_len_q;

  logic take;
  logic take_last;
  logic take_av;
  logic take_leg;
  logic [7:0] src_data;
  logic src_last;
  logic sent;
  logic idle_tick;
  logic frame_free;
  logic rd_hit;
  logic [31:0] rd_data;
  logic wr_en;
  logic rd_en;

  // Byte accepted from whichever source owns the stream
  assign take_av  = (sel_q == ATX_SEL_AV)  && av_tready  && av_source_valid;
  assign take_leg = (sel_q == ATX_SEL_LEG) && leg_tready && leg_tvalid;
  assign take     = take_av || take_leg || ((sel_q == ATX_SEL_TPP) && tpp_tready && tpp_tvalid);
  assign take_last = take && src_last;

  // Source data mux; the one-hot state names at most one source
  always_comb begin
    src_data = tpp_tdata;
    src_last = tpp_tlast;
    if (sel_q == ATX_SEL_AV) begin
      src_data = av_tdata;
      src_last = av_tlast;
    end else if (sel_q == ATX_SEL_LEG) begin
      src_data = leg_tdata;
      src_last = leg_tlast;
    end
  end

  // A byte time: the MAC takes a byte, or offers one with nothing to send
  assign sent       = mac_tvalid && mac_tready;
  assign idle_tick  = mac_tready && !mac_tvalid && (sel_q == ATX_SEL_IDLE);
  assign frame_free = (sel_q == ATX_SEL_IDLE) && !mac_tvalid;

  // Selection at frame boundaries only, once the last byte has left
  always_comb begin
    sel_d = sel_q;
    case (sel_q)
      ATX_SEL_IDLE: begin
        if (frame_free) begin
          if (av_source_valid && credit >= 0) begin
            sel_d = ATX_SEL_AV;
          end else if (tpp_tvalid) begin
            sel_d = ATX_SEL_TPP;
          end else if (leg_tvalid) begin
            sel_d = ATX_SEL_LEG;
          end
        end
      end
      ATX_SEL_AV, ATX_SEL_TPP, ATX_SEL_LEG: begin
        if (take_last) begin
          sel_d = ATX_SEL_IDLE;
        end
      end
      default: sel_d = ATX_SEL_IDLE;
    endcase
  end

  // Owner of the stream
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= ATX_SEL_IDLE;
    end else begin
      sel_q <= sel_d;
    end
  end

  // Registered ready: high only when the output stage is free next cycle,
  // which halves peak throughput but keeps every output on a flip-flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      av_tready  <= 1'b0;
      tpp_tready <= 1'b0;
      leg_tready <= 1'b0;
    end else begin
      av_tready  <= (sel_d == ATX_SEL_AV) && !take && (!mac_tvalid || mac_tready);
      tpp_tready <= (sel_d == ATX_SEL_TPP) && !take && (!mac_tvalid || mac_tready);
      leg_tready <= (sel_d == ATX_SEL_LEG) && !take && (!mac_tvalid || mac_tready);
    end
  end

  // One-byte output stage toward the MAC
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mac_tvalid <= 1'b0;
      mac_tdata  <= 8'h00;
      mac_tlast  <= 1'b0;
      mac_tuser  <= 1'b0;
      out_av_q   <= 1'b0;
    end else if (take) begin
      mac_tvalid <= 1'b1;
      mac_tdata  <= src_data;
      mac_tlast  <= src_last;
      // The count stops at the limit, so a frame of exactly limit+1 bytes is caught here
      mac_tuser  <= src_last && take_leg && (oversize_q || leg_len_q == ATX_LEG_MAX_LEN);
      out_av_q   <= take_av;
    end else if (mac_tready) begin
      mac_tvalid <= 1'b0;
      mac_tlast  <= 1'b0;
      mac_tuser  <= 1'b0;
    end
  end

  // Legacy length check: no jumbo frames, VLAN size still allowed.
  // No pause input exists, so flow control stays off.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      leg_len_q  <= 12'h000;
      oversize_q <= 1'b0;
    end else if (take_leg && leg_tlast) begin
      leg_len_q  <= 12'h000;
      oversize_q <= 1'b0;
    end else if (take_leg) begin
      if (leg_len_q == ATX_LEG_MAX_LEN) begin
        oversize_q <= 1'b1;
      end else begin
        leg_len_q <= leg_len_q + 12'h001;
      end
    end
  end

  // Credit runs per byte, never per cycle of a given rate
  atx_credit u_credit (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .gain_rate  (gain_q),
    .drain_rate (drain_q),
    .tick_gain  (av_source_valid && sel_q != ATX_SEL_AV && ((sent && !out_av_q) || idle_tick)),
    .tick_drain (sent && out_av_q),
    .clear_pos  (!av_source_valid && sel_q != ATX_SEL_AV),
    .credit_q   (credit)
  );

  // APB decode: access phase waits one cycle, writes land with pready
  assign rd_en = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    case (paddr)
      ATX_GAIN_OFS:   rd_data[ATX_RATE_LSB +: ATX_RATE_W] = gain_q;
      ATX_DRAIN_OFS:  rd_data[ATX_RATE_LSB +: ATX_RATE_W] = drain_q;
      ATX_CREDIT_OFS: rd_data = {{(32-ATX_CR_W){credit[ATX_CR_W-1]}}, credit};
      ATX_STATE_OFS: begin
        rd_data[ATX_STATE_LSB +: 4] = sel_q;
        rd_data[ATX_OVERSIZE_BIT]   = oversize_q;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // APB response registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (rd_en) begin
      pready  <= 1'b1;
      pslverr <= !rd_hit;
      prdata  <= pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Slope registers; software is trusted to keep the AV share at 75 % or less
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gain_q  <= ATX_GAIN_RST;
      drain_q <= ATX_DRAIN_RST;
    end else if (wr_en) begin
      if (paddr == ATX_GAIN_OFS) begin
        gain_q <= pwdata[ATX_RATE_LSB +: ATX_RATE_W];
      end
      if (paddr == ATX_DRAIN_OFS) begin
        drain_q <= pwdata[ATX_RATE_LSB +: ATX_RATE_W];
      end
    end
  end

  av_pick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sel_q == ATX_SEL_IDLE && !mac_tvalid && av_source_valid && credit >= 0)
    |=> sel_q == ATX_SEL_AV)
    else $error("AV not picked while in budget");

  av_budget_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sel_q == ATX_SEL_IDLE && sel_d == ATX_SEL_AV) |-> credit >= 0)
    else $error("AV picked with negative credit");

  legacy_fallback_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sel_q == ATX_SEL_IDLE && !mac_tvalid && credit < 0 && !tpp_tvalid && leg_tvalid)
    |=> sel_q == ATX_SEL_LEG)
    else $error("legacy frame not scheduled under AV debt");

  tpp_order_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sel_q == ATX_SEL_IDLE && !mac_tvalid && tpp_tvalid &&
     !(av_source_valid && credit >= 0)) |=> sel_q == ATX_SEL_TPP)
    else $error("timing packet not next after AV");

  no_preempt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sel_q != ATX_SEL_IDLE && !take_last) |=> $stable(sel_q))
    else $error("frame preempted before its last byte");

  av_stay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (take_av && av_tlast ##1 sel_q == ATX_SEL_IDLE && mac_tvalid && mac_tready
     && av_source_valid && credit >= $signed({11'h000, drain_q}))
    |=> ##1 sel_q == ATX_SEL_AV)
    else $error("AV queue not kept after a frame in budget");

endmodule : atx_arbiter

/* File: verif/atx_src.sv */
// Behavioural stream source standing in for the user AV, timing and legacy senders
`timescale 1ns/100ps
module atx_src #(
  parameter logic [7:0] BASE = 8'h00 // First byte of every frame
) (
  input  wire logic       clk_sys, // Transmit clock
  input  wire logic       rst_n,   // Async reset, active low
  input  wire logic       start,   // Begin a burst of frames
  input  wire logic [11:0] len,    // Bytes per frame
  input  wire logic [3:0] nfrm,    // Frames per burst
  input  wire logic       tready,  // Byte taken
  output logic      [7:0] tdata,   // Byte out
  output logic            tvalid,  // Byte valid
  output logic            tlast    // Last byte of frame
);
  logic [11:0] idx_q;
  logic [3:0] left_q;
  logic       tog_q;
  // Idle data toggles every cycle so a stale byte never passes for a real one
  assign tdata = tvalid ? BASE + idx_q[7:0] : {8{tog_q}};
  assign tlast = tvalid && (idx_q == len - 12'h001); // Same beat framing as legacy
  // Frame sequencing; valid only drops after a byte has been taken
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tvalid <= 1'b0;
      idx_q  <= 12'h000;
      left_q <= 4'h0;
      tog_q  <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      if (start) begin
        tvalid <= 1'b1;
        idx_q  <= 12'h000;
        left_q <= nfrm;
      end else if (tvalid && tready) begin
        if (tlast) begin
          idx_q  <= 12'h000;
          left_q <= left_q - 4'h1;
          tvalid <= (left_q != 4'h1); // Held with a frame queued else dropped
        end else begin
          idx_q <= idx_q + 12'h001;
        end
      end
    end
  end
endmodule : atx_src

/* File: verif/tb.sv */
// Self-checking bench for the AV credit shaper arbiter
`timescale 1ns/100ps
module tb;
  import atx_pkg::*;
  logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, mac_tready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  logic [7:0]  av_tdata, tpp_tdata, leg_tdata, mac_tdata;
  logic        av_source_valid, av_tlast, av_tready, tpp_tvalid, tpp_tlast, tpp_tready;
  logic        leg_tvalid, leg_tlast, leg_tready, mac_tvalid, mac_tlast, mac_tuser;
  logic        av_go, tpp_go, leg_go;
  logic [11:0] av_len, tpp_len, leg_len;
  logic [3:0]  av_nf, tpp_nf, leg_nf;
  logic [9:0]  mon_q[$]; // Bad mark, last flag and byte
  logic [9:0]  exp_q[$];
  int          failures = 0;
  int          checked = 0;

  atx_arbiter atx_arbiter_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .av_tdata(av_tdata), .av_source_valid(av_source_valid), .av_tlast(av_tlast),
    .av_tready(av_tready), .tpp_tdata(tpp_tdata), .tpp_tvalid(tpp_tvalid),
    .tpp_tlast(tpp_tlast), .tpp_tready(tpp_tready), .leg_tdata(leg_tdata),
    .leg_tvalid(leg_tvalid), .leg_tlast(leg_tlast), .leg_tready(leg_tready),
    .mac_tdata(mac_tdata), .mac_tvalid(mac_tvalid), .mac_tlast(mac_tlast),
    .mac_tuser(mac_tuser), .mac_tready(mac_tready));
  atx_src #(.BASE(8'hA0)) atx_src_av_i (.clk_sys(clk_sys), .rst_n(rst_n), .start(av_go),
    .len(av_len), .nfrm(av_nf), .tready(av_tready), .tdata(av_tdata),
    .tvalid(av_source_valid), .tlast(av_tlast));
  atx_src #(.BASE(8'h70)) atx_src_tpp_i (.clk_sys(clk_sys), .rst_n(rst_n), .start(tpp_go),
    .len(tpp_len), .nfrm(tpp_nf), .tready(tpp_tready), .tdata(tpp_tdata),
    .tvalid(tpp_tvalid), .tlast(tpp_tlast));
  atx_src #(.BASE(8'h40)) atx_src_leg_i (.clk_sys(clk_sys), .rst_n(rst_n), .start(leg_go),
    .len(leg_len), .nfrm(leg_nf), .tready(leg_tready), .tdata(leg_tdata),
    .tvalid(leg_tvalid), .tlast(leg_tlast));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Outbound byte monitor; values seen here are those sampled at the edge
  always @(posedge clk_sys) begin
    if (mac_tvalid === 1'b1 && mac_tready === 1'b1) mon_q.push_back({mac_tuser, mac_tlast, mac_tdata});
  end

  task automatic finish_test();
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(a, 1'b1, d, rd, er);
  endtask : apb_wr

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb_xfer(a, 1'b0, 32'h0000_0000, rd, er);
    check(what, rd, exp);
  endtask : rd_check

  task automatic add_frames(input logic [7:0] base, input int len, input int n,
                            input logic bad = 1'b0);
    for (int f = 0; f < n; f++) for (int i = 0; i < len; i++)
      exp_q.push_back({bad && (i == len - 1), i == len - 1, base + 8'(i)});
  endtask : add_frames

  // Start the three sources together; a zero count leaves a source quiet
  task automatic launch(input logic [3:0] an, input logic [11:0] al, input logic [3:0] tn,
                        input logic [11:0] tl, input logic [3:0] ln, input logic [11:0] ll);
    @(posedge clk_sys);
    av_go   <= (an != 4'h0);
    av_nf   <= an;
    av_len  <= al;
    tpp_go  <= (tn != 4'h0);
    tpp_nf  <= tn;
    tpp_len <= tl;
    leg_go  <= (ln != 4'h0);
    leg_nf  <= ln;
    leg_len <= ll;
    @(posedge clk_sys);
    av_go  <= 1'b0;
    tpp_go <= 1'b0;
    leg_go <= 1'b0;
  endtask : launch

  // Bounded wait for the expected byte count, then an in-order comparison
  task automatic wait_match();
    int n;
    n = 0;
    while (mon_q.size() < exp_q.size() && n < 7000) begin
      @(posedge clk_sys);
      n++;
    end
    for (int i = 0; i < exp_q.size(); i++) begin
      check("mac byte", (i < mon_q.size()) ? {22'h0, mon_q[i]} : 32'hFFFF_FFFF,
            {22'h0, exp_q[i]});
    end
    mon_q.delete();
    exp_q.delete();
  endtask : wait_match

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; mac_tready = 1'b1;
    av_go = 1'b0; tpp_go = 1'b0; leg_go = 1'b0;
    av_len = 12'h001; tpp_len = 12'h001; leg_len = 12'h001; av_nf = 4'h0; tpp_nf = 4'h0;
    leg_nf = 4'h0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_check("gain rate", ATX_GAIN_OFS, 32'((75 * 8192) / 100));
    rd_check("drain rate", ATX_DRAIN_OFS, 32'(((100 - 75) * 8192) / 100));
    rd_check("credit", ATX_CREDIT_OFS, 32'h0000_0000);
    rd_check("state", ATX_STATE_OFS, 32'h0000_0001);
    apb_wr(ATX_CREDIT_OFS, 32'h0000_1234);
    rd_check("credit kept", ATX_CREDIT_OFS, 32'h0000_0000);
    apb_xfer(8'h10, 1'b0, 32'h0000_0000, rd, er);
    check("unmapped error", {31'h0, er}, 32'h0000_0001);
    // Reset slopes: each AV frame spends what its wait earned, so AV stays parked
    add_frames(8'hA0, 3, 2);
    add_frames(8'h40, 4, 1);
    launch(4'h2, 12'h003, 4'h0, 12'h001, 4'h1, 12'h004);
    wait_match();
    rd_check("credit cleared", ATX_CREDIT_OFS, 32'h0000_0000);
    // Half share, junk in upper bits: first AV frame overspends, legacy goes next
    apb_wr(ATX_GAIN_OFS, 32'hFFFF_1000);
    apb_wr(ATX_DRAIN_OFS, 32'h0000_1000);
    rd_check("gain field", ATX_GAIN_OFS, 32'h0000_1000);
    add_frames(8'hA0, 3, 1);
    add_frames(8'h40, 4, 1);
    add_frames(8'hA0, 3, 1);
    launch(4'h2, 12'h003, 4'h0, 12'h001, 4'h1, 12'h004);
    wait_match();
    // Zero share: long AV frame hits the floor, then an oversize legacy frame
    apb_wr(ATX_GAIN_OFS, 32'h0000_0000);
    apb_wr(ATX_DRAIN_OFS, 32'h0000_2000);
    rd_check("drain field", ATX_DRAIN_OFS, 32'h0000_2000);
    add_frames(8'hA0, 1519, 1);
    add_frames(8'h40, 1519, 1, 1'b1);
    launch(4'h1, 12'h5EF, 4'h0, 12'h001, 4'h1, 12'h5EF);
    wait_match();
    rd_check("credit floor", ATX_CREDIT_OFS, 32'(ATX_CREDIT_LOWER));
    // Reset share again: timing packet, then legacy, AV once the gain repays
    apb_wr(ATX_GAIN_OFS, 32'h0000_1800);
    apb_wr(ATX_DRAIN_OFS, 32'h0000_0800);
    add_frames(8'h70, 2, 1);
    add_frames(8'h40, 3, 1);
    add_frames(8'hA0, 2, 1);
    launch(4'h1, 12'h002, 4'h1, 12'h002, 4'h1, 12'h003);
    wait_match();
    rd_check("state idle", ATX_STATE_OFS, 32'h0000_0001);
    finish_test();
  end

  // Watchdog well beyond the few thousand cycles the sequence needs
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
endmodule : tb
